// ===== ccl_partner.sv
// Purpose: Behavioural comparator core and timer capture front end.
// Assumes: Input voltages in millivolts; the bandgap is nominally 1100 mV.
// Notes:   An unpowered core drives low, so a stale result cannot leak out.
`timescale 1ns/100ps
module ccl_partner
(
	input  wire logic        i_clk,
	input  wire logic        i_power_off,
	input  wire logic        i_bandgap_enable,
	input  wire logic        i_positive_input_select,
	input  wire logic        i_capture_input,
	input  wire logic [11:0] i_pos_mv,
	input  wire logic [11:0] i_neg_mv,
	output logic             o_raw,
	output logic      [7:0]  o_capture_count
);
	logic [11:0] pos_mv;
	logic        cap_q;

	// The input mux is taken as powered, as software clears the power reduction first.
	// A selected but disabled reference gives no voltage, so it reads as 0 V.
	assign pos_mv = i_positive_input_select ? (i_bandgap_enable ? 12'h44C : 12'h000)
		: i_pos_mv;
	assign o_raw  = !i_power_off && (pos_mv > i_neg_mv);

	initial
	begin
		cap_q = 1'b0;
		o_capture_count = 8'h00;
	end

	// Every rising capture edge counts as if the timer capture interrupt were enabled.
	always @(posedge i_clk)
	begin
		cap_q <= i_capture_input;
		if (i_capture_input && !cap_q)
			o_capture_count <= o_capture_count + 8'h01;
	end
endmodule

// ===== ccl_pkg.sv
// Purpose: Shared constants and types for the comparator control logic.
// Assumes: 8-bit registers, each on one aligned 32-bit Avalon-MM word.
// Notes:   Register indices are word indices; the byte address is four times the index.
package ccl_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned CCL_ADDR_W       = 8;
	localparam logic [5:0]  CCL_IDX_DIN_DIS  = 6'h17;
	localparam logic [5:0]  CCL_IDX_CTRL     = 6'h1F;
	localparam logic [5:0]  CCL_IDX_INSEL    = 6'h20;
	localparam logic [5:0]  CCL_IDX_IRQ_STAT = 6'h21;
	localparam logic [5:0]  CCL_IDX_IRQ_MASK = 6'h22;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CCL_CTRL_FLAG_BIT  = 4;
	localparam int unsigned CCL_CTRL_RES_BIT   = 5;
	localparam logic [7:0]  CCL_CTRL_RST       = 8'h00;
	localparam logic [7:0]  CCL_INSEL_RST      = 8'h00;
	localparam logic [7:0]  CCL_DIN_DIS_RST    = 8'h00;
	localparam logic [1:0]  CCL_IRQ_RST        = 2'h0;
	localparam int unsigned CCL_IRQ_EV_FLAG    = 0;
	localparam int unsigned CCL_IRQ_EV_TOGGLE  = 1;
	localparam int unsigned CCL_CMP_PIN_BITS   = 2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CCL_SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		CCL_MODE_TOGGLE   = 2'h0,
		CCL_MODE_RESERVED = 2'h1,
		CCL_MODE_FALL     = 2'h2,
		CCL_MODE_RISE     = 2'h3
	} ccl_mode_t;

	typedef struct packed {
		logic      comparator_power_off;
		logic      bandgap_enable;
		logic      comparator_result;
		logic      comparator_irq_flag;
		logic      comparator_irq_enable;
		logic      capture_connect;
		ccl_mode_t irq_mode;
	} ccl_ctrl_t;

	typedef struct packed {
		logic [5:0] reserved;
		logic       result_pin_enable;
		logic       positive_input_select;
	} ccl_insel_t;

endpackage

// ===== ccl_sync.sv
// Purpose: Two-stage level synchroniser for the raw comparator output.
// Assumes: Input may change at any time relative to i_clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module ccl_sync
	import ccl_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_async,
	output logic      o_sync
);

	logic [CCL_SYNC_STAGES-1:0] stage;
	logic [CCL_SYNC_STAGES-1:0] next_stage;

	always_comb
	begin
		next_stage = {stage[CCL_SYNC_STAGES-2:0], i_async};
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			stage <= '0;
		else
			stage <= next_stage;
	end

	assign o_sync = stage[CCL_SYNC_STAGES-1];

endmodule

// ===== ccl_top.sv
// Purpose: Control logic around an analog comparator with an Avalon-MM register slave.
// Assumes: Pin and core inputs other than i_comparator_raw are synchronous to i_clk.
// Notes:   One answer per request; waitrequest drops one cycle after the request appears.
// Notes on behaviour
// R1 - result bit high when positive exceeds negative
// R2 - raw result synchronised, one to two cycles
// R3 - flag set on selected synchronised event
// R4 - request needs flag, enable and global enable
// R5 - vector taken or write-one clears flag
// R6 - mode: toggle, reserved, falling, rising
// R7 - power-off bit switches comparator off
// R8 - software disables interrupt before mode change
// R9 - bandgap enable bit drives reference on
// R10 - select bit picks bandgap or positive pin
// R11 - software enables bandgap before selecting it
// R12 - capture connect routes result to timer
// R13 - software enables timer capture interrupt too
// R14 - output enable drives result onto pin
// R15 - input disable bits zero the port reads
// R16 - only bits 1:0 act on comparator pins
// R17 - software clears converter power reduction first
// R18 - edges need previous sample, none after reset
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module ccl_top
	import ccl_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_sys_rst,
	input  wire logic [CCL_ADDR_W-1:0] i_avs_address,
	input  wire logic                  i_avs_read,
	input  wire logic                  i_avs_write,
	input  wire logic [31:0]           i_avs_writedata,
	input  wire logic [3:0]            i_avs_byteenable,
	output logic      [31:0]           o_avs_readdata,
	output logic                       o_avs_waitrequest,
	input  wire logic                  i_comparator_raw,
	input  wire logic                  i_global_irq_enable,
	input  wire logic                  i_irq_vector_taken,
	input  wire logic [7:0]            i_port_pin,
	output logic      [7:0]            o_port_pin_value,
	output logic                       o_comparator_power_off,
	output logic                       o_bandgap_enable,
	output logic                       o_positive_input_select,
	output logic                       o_capture_input,
	output logic                       o_result_pin,
	output logic                       o_result_pin_oe,
	output logic      [7:0]            o_digital_input_disable,
	output logic      [1:0]            o_comparator_pin_disable,
	output logic                       o_comparator_irq_req,
	output logic                       o_irq
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [CCL_ADDR_W-1:0] addr, input logic [5:0] idx);
		hit = (addr[1:0] == 2'h0) && (addr[CCL_ADDR_W-1:2] == idx);
	endfunction

	function automatic logic edge_event(input ccl_mode_t mode, input logic cur, input logic prev);
		case (mode)
			CCL_MODE_TOGGLE: edge_event = cur ^ prev;
			CCL_MODE_FALL:   edge_event = prev & ~cur;
			CCL_MODE_RISE:   edge_event = cur & ~prev;
			default:         edge_event = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Comparator result synchroniser
	// ----------------------------------------------------------------
	logic result_sync;

	ccl_sync u_sync
	(
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   (i_comparator_raw),
		.o_sync    (result_sync)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ccl_ctrl_t   ctrl;
	ccl_ctrl_t   next_ctrl;
	ccl_insel_t  insel;
	ccl_insel_t  next_insel;
	logic [7:0]  din_dis;
	logic [7:0]  next_din_dis;
	logic [1:0]  irq_stat;
	logic [1:0]  next_irq_stat;
	logic [1:0]  irq_mask;
	logic [1:0]  next_irq_mask;
	logic        prev_result;
	logic        prev_valid;
	logic        wait_q;
	logic        next_wait;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic        cmp_event;
	logic        toggle_event;
	logic        req;
	logic        wr_done;
	logic        wr_lane;

	assign req     = i_avs_read | i_avs_write;
	assign wr_done = i_avs_write & ~wait_q;
	assign wr_lane = wr_done & i_avs_byteenable[0];

	// Previous sample is only trusted once one sample has been taken.
	assign cmp_event    = prev_valid & edge_event(ctrl.irq_mode, result_sync, prev_result); // see R18
	assign toggle_event = prev_valid & (result_sync ^ prev_result);

	// ----------------------------------------------------------------
	// Register next values
	// ----------------------------------------------------------------
	always_comb
	begin
		next_ctrl     = ctrl;
		next_insel    = insel;
		next_din_dis  = din_dis;
		next_irq_mask = irq_mask;
		next_ctrl.comparator_result = result_sync; // see R1, R2
		if (wr_lane && hit(i_avs_address, CCL_IDX_CTRL))
		begin
			next_ctrl.comparator_power_off  = i_avs_writedata[7]; // see R7
			next_ctrl.bandgap_enable        = i_avs_writedata[6]; // see R9
			next_ctrl.comparator_irq_enable = i_avs_writedata[3];
			next_ctrl.capture_connect       = i_avs_writedata[2];
			next_ctrl.irq_mode              = ccl_mode_t'(i_avs_writedata[1:0]); // see R6
		end
		if (wr_lane && hit(i_avs_address, CCL_IDX_INSEL))
		begin
			next_insel.result_pin_enable     = i_avs_writedata[1];
			next_insel.positive_input_select = i_avs_writedata[0];
		end
		if (wr_lane && hit(i_avs_address, CCL_IDX_DIN_DIS))
			next_din_dis = i_avs_writedata[7:0];
		if (wr_lane && hit(i_avs_address, CCL_IDX_IRQ_MASK))
			next_irq_mask = i_avs_writedata[1:0];
		// A new event wins over a clear in the same cycle.
		next_ctrl.comparator_irq_flag = cmp_event | (ctrl.comparator_irq_flag // see R3
			& ~i_irq_vector_taken // see R5
			& ~(wr_lane && hit(i_avs_address, CCL_IDX_CTRL)
				&& i_avs_writedata[CCL_CTRL_FLAG_BIT]));
		next_irq_stat = irq_stat;
		if (wr_lane && hit(i_avs_address, CCL_IDX_IRQ_STAT))
			next_irq_stat = irq_stat & ~i_avs_writedata[1:0];
		next_irq_stat[CCL_IRQ_EV_FLAG]   = next_irq_stat[CCL_IRQ_EV_FLAG] | cmp_event;
		next_irq_stat[CCL_IRQ_EV_TOGGLE] = next_irq_stat[CCL_IRQ_EV_TOGGLE] | toggle_event;
	end

	// ----------------------------------------------------------------
	// Bus answer next values
	// ----------------------------------------------------------------
	always_comb
	begin
		next_wait  = ~(req & wait_q);
		next_rdata = rdata;
		if (req && wait_q)
		begin
			next_rdata = 32'h0000_0000;
			// The live synchroniser output is returned, so the lag stays at one to two cycles.
			if (hit(i_avs_address, CCL_IDX_CTRL))
				next_rdata[7:0] = {ctrl[7:6], result_sync, ctrl[4:0]}; // see R2
			else if (hit(i_avs_address, CCL_IDX_INSEL))
				next_rdata[7:0] = {6'h00, insel.result_pin_enable, insel.positive_input_select};
			else if (hit(i_avs_address, CCL_IDX_DIN_DIS))
				next_rdata[7:0] = din_dis;
			else if (hit(i_avs_address, CCL_IDX_IRQ_STAT))
				next_rdata[1:0] = irq_stat;
			else if (hit(i_avs_address, CCL_IDX_IRQ_MASK))
				next_rdata[1:0] = irq_mask;
			else
				next_rdata = 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			ctrl                     <= ccl_ctrl_t'(CCL_CTRL_RST);
			insel                    <= ccl_insel_t'(CCL_INSEL_RST);
			din_dis                  <= CCL_DIN_DIS_RST;
			irq_stat                 <= CCL_IRQ_RST;
			irq_mask                 <= CCL_IRQ_RST;
			prev_result              <= 1'b0;
			prev_valid               <= 1'b0;
			wait_q                   <= 1'b1;
			rdata                    <= 32'h0000_0000;
			o_port_pin_value         <= 8'h00;
			o_comparator_power_off   <= 1'b0;
			o_bandgap_enable         <= 1'b0;
			o_positive_input_select  <= 1'b0;
			o_capture_input          <= 1'b0;
			o_result_pin             <= 1'b0;
			o_result_pin_oe          <= 1'b0;
			o_digital_input_disable  <= 8'h00;
			o_comparator_pin_disable <= 2'h0;
			o_comparator_irq_req     <= 1'b0;
			o_irq                    <= 1'b0;
		end
		else
		begin
			ctrl                     <= next_ctrl;
			insel                    <= next_insel;
			din_dis                  <= next_din_dis;
			irq_stat                 <= next_irq_stat;
			irq_mask                 <= next_irq_mask;
			prev_result              <= result_sync; // see R18
			prev_valid               <= 1'b1;
			wait_q                   <= next_wait;
			rdata                    <= next_rdata;
			o_port_pin_value         <= i_port_pin & ~din_dis; // see R15
			o_comparator_power_off   <= ctrl.comparator_power_off; // see R7
			o_bandgap_enable         <= ctrl.bandgap_enable; // see R9
			o_positive_input_select  <= insel.positive_input_select; // see R10
			o_capture_input          <= result_sync & ctrl.capture_connect; // see R12
			o_result_pin             <= result_sync & insel.result_pin_enable; // see R14
			o_result_pin_oe          <= insel.result_pin_enable; // see R14
			o_digital_input_disable  <= din_dis;
			o_comparator_pin_disable <= din_dis[CCL_CMP_PIN_BITS-1:0]; // see R16
			o_comparator_irq_req     <= ctrl.comparator_irq_flag // see R4
				& ctrl.comparator_irq_enable & i_global_irq_enable;
			o_irq                    <= |(irq_stat & irq_mask);
		end
	end

	assign o_avs_readdata    = rdata;
	assign o_avs_waitrequest = wait_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_sync_delay: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R2
		1 ##2 (ctrl.comparator_result == $past(i_comparator_raw, 3)))
		else $error("synchronised result does not follow raw input");

	a_rise_sets_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R3
		(prev_valid && ctrl.irq_mode == CCL_MODE_RISE && result_sync && !prev_result)
		|=> ctrl.comparator_irq_flag)
		else $error("rising edge did not set the flag");

	a_fall_sets_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R6
		(prev_valid && ctrl.irq_mode == CCL_MODE_FALL && !result_sync && prev_result)
		|=> ctrl.comparator_irq_flag)
		else $error("falling edge did not set the flag");

	a_reserved_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R6
		(ctrl.irq_mode == CCL_MODE_RESERVED && !ctrl.comparator_irq_flag)
		|=> !ctrl.comparator_irq_flag)
		else $error("reserved mode set the flag");

	a_vector_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R5
		(i_irq_vector_taken && !cmp_event) |=> !ctrl.comparator_irq_flag)
		else $error("vector taken did not clear the flag");

	a_irq_request: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R4
		(ctrl.comparator_irq_flag && ctrl.comparator_irq_enable && i_global_irq_enable)
		|=> o_comparator_irq_req)
		else $error("interrupt request missing");

	a_capture_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R12
		!ctrl.capture_connect |=> !o_capture_input)
		else $error("capture input driven while disconnected");

	a_result_pin: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R14
		insel.result_pin_enable |=> (o_result_pin == $past(result_sync)) && o_result_pin_oe)
		else $error("result pin does not carry the result");

	a_port_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R15
		1 |=> (o_port_pin_value & $past(din_dis)) == 8'h00)
		else $error("disabled input reads nonzero");

	a_no_first_edge: assert property (@(posedge i_clk) // see R18
		i_sys_rst |=> !cmp_event)
		else $error("event detected right after reset");

	a_bus_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(req && wait_q) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("bus answer not one cycle after request");

endmodule

// ===== tb_comparator_control_logic.sv
// Purpose: Self-checking bench for the comparator control logic.
// Assumes: Avalon answer comes when waitrequest is sampled low.
// Notes:   Fixed waits cover only the synchroniser and register lag.
`timescale 1ns/100ps
module tb_comparator_control_logic
	import ccl_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, rd_s = 1'b0, wr_s = 1'b0;
	logic        gie = 1'b0, vec = 1'b0, raw, cap, rpin, roe, pwr, bg, psel, req, irq, wait_s;
	logic [7:0]  addr = 8'h00, pin = 8'h00, pinv, ddis, ccount;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0]  cdis;
	logic [11:0] pos = 12'h000, neg = 12'h100;
	int          mismatches = 0, n_compared = 0;

	always #2 clk = ~clk;

	ccl_top u_ccl_top (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd_s),
		.i_avs_write(wr_s), .i_avs_writedata(wdata), .i_avs_byteenable(4'h1),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_s), .i_comparator_raw(raw),
		.i_global_irq_enable(gie), .i_irq_vector_taken(vec), .i_port_pin(pin),
		.o_port_pin_value(pinv), .o_comparator_power_off(pwr), .o_bandgap_enable(bg),
		.o_positive_input_select(psel), .o_capture_input(cap), .o_result_pin(rpin),
		.o_result_pin_oe(roe), .o_digital_input_disable(ddis),
		.o_comparator_pin_disable(cdis), .o_comparator_irq_req(req), .o_irq(irq));

	ccl_partner u_ccl_partner (.i_clk(clk), .i_power_off(pwr), .i_bandgap_enable(bg),
		.i_positive_input_select(psel), .i_capture_input(cap), .i_pos_mv(pos),
		.i_neg_mv(neg), .o_raw(raw), .o_capture_count(ccount));

	task automatic conclude();
		if (mismatches == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// The request is held until waitrequest is seen low, then dropped at that edge.
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
		output logic [7:0] d);
		int n;
		@(posedge clk);
		addr  <= {idx, 2'h0};
		rd_s  <= !wr;
		wr_s  <= wr;
		wdata <= {24'h000000, wd};
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (wait_s === 1'b0)
				break;
		end
		d = rdata[7:0];
		rd_s <= 1'b0;
		wr_s <= 1'b0;
		if (n == 50)
		begin
			mismatches++;
			$display("[FAIL] %0t bus timeout", $time);
			conclude();
		end
	endtask

	task automatic regw(input logic [5:0] idx, input logic [7:0] wd);
		logic [7:0] d;
		bus(1'b1, idx, wd, d);
	endtask

	task automatic regr(input logic [5:0] idx, output logic [7:0] d);
		bus(1'b0, idx, 8'h00, d);
	endtask

	function automatic logic exp_flag(input logic [1:0] m, input logic rose);
		return (m == 2'h0) || (m == 2'h2 && !rose) || (m == 2'h3 && rose);
	endfunction

	initial
	begin
		logic [7:0] d;
		logic [7:0] dis;
		logic [1:0] m;
		logic       e;
		logic       pe;
		logic [7:0] cnt;
		logic [5:0] ridx [6] = '{6'h17, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h01};
		int         i;
		void'($urandom(84769));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		foreach (ridx[k])
		begin
			regr(ridx[k], d);
			chk(d, 8'h00, "reset value");
		end
		dis = $urandom;
		regw(CCL_IDX_DIN_DIS, dis);
		pin <= $urandom;
		repeat (3) @(posedge clk);
		chk(pinv, pin & ~dis, "pin read");
		chk({6'h00, cdis}, {6'h00, dis[1:0]}, "cmp pins");
		chk(ddis, dis, "disable copy");
		regr(CCL_IDX_DIN_DIS, d);
		chk(d, dis, "disable readback");
		for (i = 0; i < 4; i++)
		begin
			m = 2'(i);
			regw(CCL_IDX_CTRL, {4'h1, 2'h0, m});
			pos <= 12'h200;
			repeat (8) @(posedge clk);
			regr(CCL_IDX_CTRL, d);
			chk(d, {2'h0, 1'b1, exp_flag(m, 1'b1), 2'h0, m}, "rise");
			regw(CCL_IDX_CTRL, {4'h1, 2'h0, m});
			regr(CCL_IDX_CTRL, d);
			chk(d, {4'h2, 2'h0, m}, "w1c");
			pos <= 12'h000;
			repeat (8) @(posedge clk);
			regr(CCL_IDX_CTRL, d);
			chk(d, {3'h0, exp_flag(m, 1'b0), 2'h0, m}, "fall");
			regw(CCL_IDX_CTRL, {4'h1, 2'h0, m});
		end
		regw(CCL_IDX_CTRL, 8'h1B);
		gie <= 1'b1;
		pos <= 12'h200;
		repeat (8) @(posedge clk);
		chk({7'h0, req}, 8'h01, "req");
		vec <= 1'b1;
		@(posedge clk);
		vec <= 1'b0;
		repeat (3) @(posedge clk);
		chk({7'h0, req}, 8'h00, "vector clear");
		gie <= 1'b0;
		pos <= 12'h000;
		repeat (4) @(posedge clk);
		pos <= 12'h200;
		repeat (8) @(posedge clk);
		chk({7'h0, req}, 8'h00, "gie off");
		gie <= 1'b1;
		repeat (3) @(posedge clk);
		chk({7'h0, req}, 8'h01, "gie on");
		regw(CCL_IDX_CTRL, 8'h03);
		repeat (3) @(posedge clk);
		chk({7'h0, req}, 8'h00, "enable off");
		regr(CCL_IDX_IRQ_STAT, d);
		chk(d, 8'h03, "status");
		regw(CCL_IDX_IRQ_MASK, 8'h02);
		repeat (3) @(posedge clk);
		chk({7'h0, irq}, 8'h01, "irq");
		regw(CCL_IDX_IRQ_MASK, 8'h00);
		repeat (3) @(posedge clk);
		chk({7'h0, irq}, 8'h00, "masked");
		regw(CCL_IDX_IRQ_STAT, 8'h03);
		regr(CCL_IDX_IRQ_STAT, d);
		chk(d, 8'h00, "status w1c");
		regw(CCL_IDX_IRQ_MASK, 8'h03);
		repeat (3) @(posedge clk);
		chk({7'h0, irq}, 8'h00, "cleared");
		regw(CCL_IDX_CTRL, 8'h04);
		regw(CCL_IDX_INSEL, 8'h02);
		pe  = 1'b1;
		cnt = ccount;
		for (i = 0; i < 8; i++)
		begin
			pos <= 12'($urandom);
			neg <= 12'($urandom);
			repeat (6) @(posedge clk);
			e = pos > neg;
			cnt = cnt + {7'h0, e && !pe};
			pe = e;
			regr(CCL_IDX_CTRL, d);
			chk({7'h0, d[5]}, {7'h0, e}, "result");
			chk({7'h0, cap}, {7'h0, e}, "capture");
			chk({6'h0, roe, rpin}, {6'h0, 1'b1, e}, "result pin");
		end
		chk(ccount, cnt, "capture edges");
		pos <= 12'h300;
		neg <= 12'h100;
		regw(CCL_IDX_CTRL, 8'h00);
		regw(CCL_IDX_INSEL, 8'h00);
		repeat (6) @(posedge clk);
		chk({5'h0, cap, roe, rpin}, 8'h00, "disconnected");
		// Reserved mode keeps the select switch glitch from setting the flag.
		regw(CCL_IDX_CTRL, 8'h51);
		regw(CCL_IDX_INSEL, 8'h01);
		neg <= 12'h3E8;
		repeat (6) @(posedge clk);
		chk({6'h0, bg, psel}, 8'h03, "bandgap");
		regr(CCL_IDX_CTRL, d);
		chk(d, 8'h61, "bandgap high");
		neg <= 12'h4B0;
		repeat (6) @(posedge clk);
		regr(CCL_IDX_CTRL, d);
		chk(d, 8'h41, "bandgap low");
		regw(CCL_IDX_CTRL, 8'hC0);
		repeat (3) @(posedge clk);
		chk({7'h0, pwr}, 8'h01, "power off");
		regw(CCL_IDX_CTRL, 8'h40);
		repeat (3) @(posedge clk);
		chk({7'h0, pwr}, 8'h00, "power on");
		conclude();
	end
endmodule
